/* File: src/cmd_step_check.sv */
// Checks one bus write cycle against the unlock pattern of its step.
module cmd_step_check import flash_seq_pkg::*; (
	input wire logic [2:0] step, // Bus write cycle index within a command.
	input wire logic [31:0] addr, // Write address.
	input wire logic [31:0] data, // Write data.
	output logic unlock_ok, // Cycle matches the unlock pattern of its step.
	output logic at_cmd_addr // Address is the command address.
);

	// Compares the decoded address bits and the full data word.
	function automatic logic hit(input logic [31:0] a, input logic [15:0] ra,
			input logic [31:0] d, input logic [31:0] rd);
		return (a[15:0] == ra) && (d == rd);
	endfunction

	// Steps 0 and 3 carry the first unlock word, 1 and 4 the second.
	always_comb begin
		case (step)
			3'h0, 3'h3: unlock_ok = hit(addr, UNLOCK_ADDR1, data, UNLOCK_DATA1);
			3'h1, 3'h4: unlock_ok = hit(addr, UNLOCK_ADDR2, data, UNLOCK_DATA2);
			default: unlock_ok = 1'b0;
		endcase
	end

	assign at_cmd_addr = (addr[15:0] == UNLOCK_ADDR1);
endmodule // cmd_step_check

/* File: src/flash_bus_if.sv */
// Bus between the CPU end and the flash command sequencer.
interface flash_bus_if;
	logic wr_valid;
	logic wr_word;
	logic [31:0] addr;
	logic [31:0] wdata;
	logic rd_valid;
	logic rd_ack;
	logic rd_ok;
	logic [31:0] rdata;
	logic ready_busy_flag;

	modport dev (
		input wr_valid, wr_word, addr, wdata, rd_valid,
		output rd_ack, rd_ok, rdata, ready_busy_flag
	);

	modport cpu (
		output wr_valid, wr_word, addr, wdata, rd_valid,
		input rd_ack, rd_ok, rdata, ready_busy_flag
	);
endinterface

/* File: src/flash_command_sequencer.sv */
// Device end: flash command sequencer with read mode and automatic operation.

module flash_command_sequencer import flash_seq_pkg::*; #(
	parameter int unsigned PROG_CYCLES = PROG_CYCLES_DFLT, // Page program time.
	parameter int unsigned ERASE_CYCLES = ERASE_CYCLES_DFLT // Erase time.
) (
	input wire logic core_clk, // System clock, 125 MHz.
	input wire logic srst, // Synchronous reset, active high.
	flash_bus_if.dev bus, // CPU bus cycles.
	input wire logic [31:0] array_rdata, // Array word at the current bus read address, in the request cycle.
	input wire logic array_fail, // Array reports a failed operation.
	output logic array_wr, // Pulse: write array_wdata at array_addr.
	output logic array_re, // Pulse: array read at array_addr.
	output logic [31:0] array_addr, // Array byte address.
	output logic [31:0] array_wdata, // Array write data.
	output logic erase_go, // Pulse: erase blocks in erase_mask.
	output logic [3:0] erase_mask, // Blocks to erase.
	output logic [3:0] protect_mask, // Protected blocks.
	output logic [2:0] seq_state // Sequencer state for observation.
);

	// ==========================================================
	// Declarations
	seq_state_t state_ff;
	logic [2:0] step_ff;
	logic erase_kind_ff;
	logic [6:0] word_ff;
	logic [TIMER_W-1:0] timer_ff;
	logic [3:0] protect_ff;
	logic array_wr_ff;
	logic array_re_ff;
	logic [31:0] array_addr_ff;
	logic [31:0] array_wdata_ff;
	logic erase_go_ff;
	logic [3:0] erase_mask_ff;
	logic rd_ack_ff;
	logic rd_ok_ff;
	logic [31:0] rdata_ff;
	logic wr_go;
	logic bad_size;
	logic is_reset;
	logic unlock_ok;
	logic at_cmd_addr;
	logic [1:0] blk;
	logic page_top;
	logic chip_ok;
	logic block_ok;
	logic launch_prog;
	logic launch_erase;
	logic page_reject;
	logic readable;

	// ==========================================================
	// Cycle decode

	// Checks each write against the unlock pattern of the current step.
	cmd_step_check u_check (
		.step(step_ff),
		.addr(bus.addr),
		.data(bus.wdata),
		.unlock_ok(unlock_ok),
		.at_cmd_addr(at_cmd_addr)
	);

	// Classifies the write in this cycle.
	assign wr_go = bus.wr_valid && bus.wr_word;
	assign bad_size = bus.wr_valid && !bus.wr_word;
	assign is_reset = (bus.wdata == CMD_RESET);
	assign blk = bus.addr[BLOCK_MSB:BLOCK_LSB];
	assign page_top = (bus.addr[PAGE_LSB-1:0] == '0);

	// Erase launches only when the final cycle names an unprotected target.
	assign chip_ok = at_cmd_addr && (bus.wdata == CMD_CHIP) &&
		(protect_ff != ALL_PROTECTED);
	assign block_ok = (bus.wdata == CMD_BLOCK) && !protect_ff[blk];
	assign launch_erase = (state_ff == S_CMD) && wr_go && !is_reset &&
		(step_ff == LAST_STEP) && erase_kind_ff && (chip_ok || block_ok);

	// The first page word must be a page top inside an unprotected block.
	assign page_reject = (word_ff == 7'h00) && (!page_top || protect_ff[blk]);
	assign launch_prog = (state_ff == S_PAGE) && wr_go && !page_reject &&
		(word_ff == LAST_WORD);

	// ==========================================================
	// Mode and step tracking

	// Walks the ordered bus write cycles and picks the operation.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_ff <= S_READ;
			step_ff <= 3'h0;
			erase_kind_ff <= 1'b0;
		end else begin
			case (state_ff)
				S_READ: begin
					step_ff <= 3'h0;
					// A lone F0 word keeps read mode; an unlock word opens a command.
					if (wr_go && !is_reset && unlock_ok) begin
						state_ff <= S_CMD;
						step_ff <= 3'h1;
					end
				end
				S_CMD: begin
					if (bad_size) begin
						state_ff <= S_READ;
					end else if (wr_go && is_reset) begin
						state_ff <= S_READ;
					end else if (wr_go) begin
						step_ff <= step_ff + 3'h1;
						case (step_ff)
							3'h2: begin
								erase_kind_ff <= (bus.wdata == CMD_ERASE);
								if (!at_cmd_addr) begin
									state_ff <= S_READ;
								end else if (bus.wdata == CMD_ID) begin
									state_ff <= S_ID;
								end else if (bus.wdata == CMD_PAGE) begin
									state_ff <= S_PAGE;
								end else if (bus.wdata != CMD_ERASE &&
										bus.wdata != CMD_PROTECT) begin
									state_ff <= S_READ;
								end
							end
							3'h3: begin
								// Protect ends on its code word; erase needs an unlock.
								if (!erase_kind_ff || !unlock_ok) begin
									state_ff <= S_READ;
								end
							end
							3'h5: begin
								state_ff <= launch_erase ? S_AUTO : S_READ;
							end
							default: begin
								if (!unlock_ok) begin
									state_ff <= S_READ;
								end
							end
						endcase
					end
				end
				S_PAGE: begin
					// Software reset has no effect on page words.
					if (wr_go && page_reject) begin
						state_ff <= S_READ;
					end else if (launch_prog) begin
						state_ff <= S_AUTO;
					end
				end
				S_AUTO: begin
					// Bus writes are ignored until the array finishes.
					if (array_fail) begin
						state_ff <= S_FAIL;
					end else if (timer_ff == '0) begin
						state_ff <= S_READ;
					end
				end
				S_ID, S_FAIL: begin
					if (wr_go && is_reset) begin
						state_ff <= S_READ;
					end
				end
				default: begin
					state_ff <= S_READ;
				end
			endcase
		end
	end

	// Counts page words from the page top onward.
	always_ff @(posedge core_clk) begin
		if (srst || state_ff != S_PAGE) begin
			word_ff <= 7'h00;
		end else if (wr_go) begin
			word_ff <= word_ff + 7'h01;
		end
	end

	// Times the automatic operation without any CPU involvement.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			timer_ff <= '0;
		end else if (launch_prog) begin
			timer_ff <= TIMER_W'(PROG_CYCLES - 1);
		end else if (launch_erase) begin
			timer_ff <= TIMER_W'(ERASE_CYCLES - 1);
		end else if (state_ff == S_AUTO && timer_ff != '0) begin
			timer_ff <= timer_ff - 1'b1;
		end
	end

	// Accumulates the protection code written in the fourth cycle.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			protect_ff <= PROTECT_RST;
		end else if (state_ff == S_CMD && wr_go && !is_reset &&
				step_ff == 3'h3 && !erase_kind_ff) begin
			protect_ff <= protect_ff | bus.wdata[3:0];
		end
	end

	// ==========================================================
	// Array side

	// Passes page words and erase requests to the array.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			array_wr_ff <= 1'b0;
			array_re_ff <= 1'b0;
			array_addr_ff <= '0;
			array_wdata_ff <= '0;
			erase_go_ff <= 1'b0;
			erase_mask_ff <= 4'h0;
		end else begin
			array_wr_ff <= (state_ff == S_PAGE) && wr_go && !page_reject;
			array_re_ff <= bus.rd_valid && readable;
			erase_go_ff <= launch_erase;
			if (bus.wr_valid || bus.rd_valid) begin
				array_addr_ff <= bus.addr;
			end
			if (bus.wr_valid) begin
				array_wdata_ff <= bus.wdata;
			end
			if (launch_erase) begin
				erase_mask_ff <= chip_ok ? ~protect_ff : (4'h1 << blk);
			end
		end
	end

	// ==========================================================
	// Read side

	// Array data is only visible in read mode; the ID word in ID mode.
	assign readable = (state_ff == S_READ) || (state_ff == S_ID);

	// Answers a read one cycle after the request.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rd_ack_ff <= 1'b0;
			rd_ok_ff <= 1'b0;
			rdata_ff <= '0;
		end else begin
			rd_ack_ff <= bus.rd_valid;
			rd_ok_ff <= bus.rd_valid && readable;
			if (!bus.rd_valid || !readable) begin
				rdata_ff <= '0;
			end else if (state_ff == S_ID) begin
				rdata_ff <= ID_CODE;
			end else begin
				rdata_ff <= array_rdata;
			end
		end
	end

	// Flag is low from the page command word or an erase launch until the array completes; after a failure, until a reset word.
	assign bus.ready_busy_flag = (state_ff != S_PAGE) && (state_ff != S_AUTO) &&
		(state_ff != S_FAIL);
	assign bus.rd_ack = rd_ack_ff;
	assign bus.rd_ok = rd_ok_ff;
	assign bus.rdata = rdata_ff;
	assign array_wr = array_wr_ff;
	assign array_re = array_re_ff;
	assign array_addr = array_addr_ff;
	assign array_wdata = array_wdata_ff;
	assign erase_go = erase_go_ff;
	assign erase_mask = erase_mask_ff;
	assign protect_mask = protect_ff;
	assign seq_state = state_ff;
endmodule // flash_command_sequencer

/* File: src/flash_cpu_master.sv */
// CPU end: issues flash command sequences and reads over the flash bus.
module flash_cpu_master import flash_seq_pkg::*; (
	input wire logic core_clk, // System clock, 125 MHz.
	input wire logic srst, // Synchronous reset, active high.
	flash_bus_if.cpu bus, // Bus toward the sequencer.
	input wire logic op_start, // Pulse: start the operation in op_kind.
	input wire op_kind_t op_kind, // Operation to issue.
	input wire logic [31:0] op_addr, // Target address.
	input wire logic [3:0] op_code, // Protection code.
	input wire logic abort, // Cancel a command part-way.
	input wire logic [31:0] word_data, // Next page word.
	output logic word_take, // Pulse: word_data consumed.
	input wire logic rd_start, // Pulse: read rd_addr.
	input wire logic [31:0] rd_addr, // Read address.
	output logic [31:0] rd_data, // Read result.
	output logic rd_done, // Pulse: read finished.
	output logic rd_fail, // Read was refused.
	output logic op_busy, // Operation or read in progress.
	output logic op_done // Pulse: command writes finished.
);

	// ==========================================================
	// Declarations
	host_state_t state_ff;
	op_kind_t kind_ff;
	logic [31:0] base_ff;
	logic [3:0] code_ff;
	logic [2:0] step_ff;
	logic [6:0] word_ff;
	logic wr_valid_ff;
	logic rd_valid_ff;
	logic [31:0] addr_ff;
	logic [31:0] wdata_ff;
	logic [31:0] rd_data_ff;
	logic rd_done_ff;
	logic rd_fail_ff;
	logic op_done_ff;
	logic [63:0] entry;
	logic [2:0] last;

	// Address and data of each bus write cycle of a command.
	function automatic logic [63:0] seq_entry(input op_kind_t k, input logic [2:0] s,
			input logic [31:0] b, input logic [3:0] c);
		logic [31:0] a1;
		logic [31:0] a2;
		a1 = {16'h0000, UNLOCK_ADDR1};
		a2 = {16'h0000, UNLOCK_ADDR2};
		case (s)
			3'h0: seq_entry = (k == OP_READ_CMD) ? {b, CMD_RESET} : {a1, UNLOCK_DATA1};
			3'h1, 3'h4: seq_entry = {a2, UNLOCK_DATA2};
			3'h2: begin
				case (k)
					OP_ID: seq_entry = {a1, CMD_ID};
					OP_PAGE: seq_entry = {a1, CMD_PAGE};
					OP_PROTECT: seq_entry = {a1, CMD_PROTECT};
					OP_CHIP, OP_BLOCK: seq_entry = {a1, CMD_ERASE};
					default: seq_entry = {a1, CMD_RESET};
				endcase
			end
			3'h3: seq_entry = (k == OP_PROTECT) ? {b, 28'h0000000, c} : {a1, UNLOCK_DATA1};
			default: seq_entry = (k == OP_CHIP) ? {a1, CMD_CHIP} : {b, CMD_BLOCK};
		endcase
	endfunction

	assign entry = seq_entry(kind_ff, step_ff, base_ff, code_ff);
	assign last = (kind_ff == OP_READ_CMD) ? 3'h0 : (kind_ff == OP_PROTECT) ? 3'h3 :
		(kind_ff == OP_CHIP || kind_ff == OP_BLOCK) ? LAST_STEP : 3'h2;

	// ==========================================================
	// Sequencing

	// Waits for the flag, sends a read command, then the command words.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_ff <= H_IDLE;
			kind_ff <= OP_READ_CMD;
			base_ff <= '0;
			code_ff <= 4'h0;
			step_ff <= 3'h0;
			word_ff <= 7'h00;
			wr_valid_ff <= 1'b0;
			rd_valid_ff <= 1'b0;
			addr_ff <= '0;
			wdata_ff <= '0;
			op_done_ff <= 1'b0;
		end else begin
			wr_valid_ff <= 1'b0;
			rd_valid_ff <= 1'b0;
			op_done_ff <= 1'b0;
			case (state_ff)
				H_IDLE: begin
					step_ff <= 3'h0;
					word_ff <= 7'h00;
					if (op_start) begin
						kind_ff <= op_kind;
						base_ff <= op_addr;
						code_ff <= op_code;
						state_ff <= H_WAIT;
					end else if (rd_start) begin
						rd_valid_ff <= 1'b1;
						addr_ff <= rd_addr;
						state_ff <= H_READ;
					end
				end
				H_WAIT: begin
					if (bus.ready_busy_flag) begin
						state_ff <= H_PRE;
					end
				end
				H_PRE: begin
					wr_valid_ff <= 1'b1;
					addr_ff <= base_ff;
					wdata_ff <= CMD_RESET;
					state_ff <= H_SEQ;
				end
				H_SEQ: begin
					// No reads are made until the last word is sent.
					if (abort && kind_ff != OP_READ_RESET) begin
						kind_ff <= OP_READ_RESET;
						step_ff <= 3'h0;
					end else begin
						wr_valid_ff <= 1'b1;
						addr_ff <= entry[63:32];
						wdata_ff <= entry[31:0];
						step_ff <= step_ff + 3'h1;
						if (step_ff == last) begin
							state_ff <= (kind_ff == OP_PAGE) ? H_PAGE : H_IDLE;
							op_done_ff <= (kind_ff != OP_PAGE);
						end
					end
				end
				H_PAGE: begin
					wr_valid_ff <= 1'b1;
					addr_ff <= {base_ff[31:PAGE_LSB], word_ff, 2'b00};
					wdata_ff <= word_data;
					word_ff <= word_ff + 7'h01;
					if (word_ff == LAST_WORD) begin
						state_ff <= H_IDLE;
						op_done_ff <= 1'b1;
					end
				end
				H_READ: begin
					if (bus.rd_ack) begin
						state_ff <= H_IDLE;
					end
				end
				default: begin
					state_ff <= H_IDLE;
				end
			endcase
		end
	end

	// Captures the read answer.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rd_data_ff <= '0;
			rd_done_ff <= 1'b0;
			rd_fail_ff <= 1'b0;
		end else begin
			rd_done_ff <= (state_ff == H_READ) && bus.rd_ack;
			if (state_ff == H_READ && bus.rd_ack) begin
				rd_data_ff <= bus.rdata;
				rd_fail_ff <= !bus.rd_ok;
			end
		end
	end

	// Every command cycle is a whole 32-bit word.
	assign bus.wr_word = 1'b1;
	assign bus.wr_valid = wr_valid_ff;
	assign bus.rd_valid = rd_valid_ff;
	assign bus.addr = addr_ff;
	assign bus.wdata = wdata_ff;
	assign word_take = (state_ff == H_PAGE);
	assign rd_data = rd_data_ff;
	assign rd_done = rd_done_ff;
	assign rd_fail = rd_fail_ff;
	assign op_busy = (state_ff != H_IDLE);
	assign op_done = op_done_ff;
endmodule // flash_cpu_master

/* File: src/flash_seq_pkg.sv */
// Shared constants and types for the flash command sequencer and its CPU end.
package flash_seq_pkg;

	// ==========================================================
	// Bus and clock
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned ADDR_W = 32;
	localparam int unsigned DATA_W = 32;

	// ==========================================================
	// Command cycle addresses and data (low 16 address bits are decoded).
	localparam logic [15:0] UNLOCK_ADDR1 = 16'h5400;
	localparam logic [15:0] UNLOCK_ADDR2 = 16'hAA00;
	localparam logic [31:0] UNLOCK_DATA1 = 32'h0000_00AA;
	localparam logic [31:0] UNLOCK_DATA2 = 32'h0000_0055;
	localparam logic [31:0] CMD_RESET = 32'h0000_00F0;
	localparam logic [31:0] CMD_ID = 32'h0000_0090;
	localparam logic [31:0] CMD_PAGE = 32'h0000_00A0;
	localparam logic [31:0] CMD_ERASE = 32'h0000_0080;
	localparam logic [31:0] CMD_PROTECT = 32'h0000_009A;
	localparam logic [31:0] CMD_CHIP = 32'h0000_0010;
	localparam logic [31:0] CMD_BLOCK = 32'h0000_0030;
	localparam logic [2:0] LAST_STEP = 3'h5;

	// ==========================================================
	// Array layout
	localparam int unsigned PAGE_LSB = 9;
	localparam logic [6:0] LAST_WORD = 7'h7F;
	localparam int unsigned BLOCK_LSB = 17;
	localparam int unsigned BLOCK_MSB = 18;
	localparam logic [3:0] PROTECT_RST = 4'h0;
	localparam logic [3:0] ALL_PROTECTED = 4'hF;
	// Identification word; the value is arbitrary.
	localparam logic [31:0] ID_CODE = 32'h0000_5A5A;

	// ==========================================================
	// Automatic operation times
	localparam int unsigned PROG_TIME_US = 40;
	localparam int unsigned ERASE_TIME_US = 100;
	localparam int unsigned PROG_CYCLES_DFLT = PROG_TIME_US * CLK_MHZ;
	localparam int unsigned ERASE_CYCLES_DFLT = ERASE_TIME_US * CLK_MHZ;
	localparam int unsigned TIMER_W = 24;

	// ==========================================================
	// State and operation types
	typedef enum logic [2:0] {
		S_READ = 3'h0,
		S_CMD = 3'h1,
		S_PAGE = 3'h3,
		S_AUTO = 3'h2,
		S_FAIL = 3'h6,
		S_ID = 3'h4
	} seq_state_t;

	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_WAIT = 3'h1,
		H_PRE = 3'h3,
		H_SEQ = 3'h2,
		H_PAGE = 3'h6,
		H_READ = 3'h4
	} host_state_t;

	typedef enum logic [2:0] {
		OP_READ_CMD = 3'h0,
		OP_READ_RESET = 3'h1,
		OP_ID = 3'h2,
		OP_PAGE = 3'h3,
		OP_CHIP = 3'h4,
		OP_BLOCK = 3'h5,
		OP_PROTECT = 3'h6
	} op_kind_t;

endpackage

/* File: verif/flash_seq_asserts.sv */
// Concurrent checks on the bus that joins the CPU end and the sequencer.
module flash_seq_asserts import flash_seq_pkg::*; #(
	parameter int unsigned ERASE_CYCLES = ERASE_CYCLES_DFLT // Erase time.
) (
	input wire logic core_clk, // System clock.
	input wire logic srst, // Synchronous reset.
	input wire logic wr_valid, // Write strobe.
	input wire logic wr_word, // Word size.
	input wire logic [31:0] addr, // Address.
	input wire logic [31:0] wdata, // Write data.
	input wire logic rd_valid, // Read request.
	input wire logic rd_ack, // Read answer.
	input wire logic rd_ok, // Read accepted.
	input wire logic [31:0] rdata, // Read data.
	input wire logic ready_busy_flag // Ready flag.
);
	localparam int E_LO = ERASE_CYCLES;
	localparam int E_HI = ERASE_CYCLES + 2;
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);

	// ==========================================================
	// Command steps
	// These match the write cycles that the CPU end issues back to back.
	sequence wr_at(logic [15:0] a, logic [31:0] d);
		wr_valid && addr[15:0] == a && wdata == d;
	endsequence
	sequence unlock;
		wr_at(UNLOCK_ADDR1, UNLOCK_DATA1) ##1 wr_at(UNLOCK_ADDR2, UNLOCK_DATA2);
	endsequence
	sequence chip_go;
		unlock ##1 (wr_valid && wdata == CMD_ERASE) ##1 unlock ##1 wr_at(UNLOCK_ADDR1, CMD_CHIP);
	endsequence

	// ==========================================================
	// Assertions
	// Most tie an answer or the flag to the bus cycles or reset that cause it; a_word_size and a_no_mixed check writes only.
	a_read_answer: assert property (rd_valid |=> rd_ack)
		else $error("read request got no answer");
	a_refused_zero: assert property (rd_ack && !rd_ok |-> rdata == 32'h0)
		else $error("refused read carried data");
	a_busy_refuses: assert property (rd_valid && !ready_busy_flag |=> rd_ack && !rd_ok)
		else $error("read served while busy");
	a_reset_ready: assert property ($fell(srst) |-> ready_busy_flag)
		else $error("not ready after reset");
	a_busy_held: assert property (chip_go |=> !ready_busy_flag [*8])
		else $error("busy flag dropped too early");
	a_erase_starts: assert property (chip_go |=> !ready_busy_flag)
		else $error("chip erase did not start");
	a_erase_ends: assert property (chip_go |-> ##[E_LO:E_HI] ready_busy_flag)
		else $error("chip erase did not end in time");
	a_reset_cmd: assert property (unlock ##1 wr_at(UNLOCK_ADDR1, CMD_RESET) |=> ready_busy_flag)
		else $error("reset command left device busy");
	a_word_size: assert property (wr_valid |-> wr_word)
		else $error("command write not a full word");
	a_no_mixed: assert property (wr_valid |-> !rd_valid)
		else $error("read mixed into command");
	a_ready_first: assert property (wr_valid && wdata == CMD_RESET && !$past(wr_valid)
		|-> $past(ready_busy_flag))
		else $error("sequence began while busy");
endmodule // flash_seq_asserts

/* File: verif/tb_top.sv */
// Top testbench: CPU end and sequencer joined, plus a lone sequencer driven directly.
module tb_top import flash_seq_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned ERASE_N = 16; // Shortened erase time.
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic op_start = 1'b0, abort = 1'b0, rd_start = 1'b0, array_fail = 1'b0, fail_b = 1'b0;
	op_kind_t op_kind = OP_READ_CMD;
	logic [31:0] op_addr = 32'h0, rd_addr = 32'h0, rd_data;
	logic [3:0] op_code = 4'h0, erase_mask, protect_mask;
	logic [2:0] seq_state, state_b;
	logic [7:0] wcnt = 8'h00;
	logic array_wr, erase_go, word_take, rd_done, rd_fail, op_busy, op_done;
	int fails = 0, num_checks = 0, n_wr = 0, n_erase = 0, n_bus = 0, n_half = 0, e0 = 0;
	flash_bus_if bus ();
	flash_bus_if bus_b ();

	// ==========================================================
	// Clock, instances and counters
	// The clock toggles every half period of 4 ns.
	initial begin
		forever #4 core_clk = ~core_clk;
	end
	flash_command_sequencer #(.PROG_CYCLES(8), .ERASE_CYCLES(ERASE_N)) i_flash_command_sequencer (
		.core_clk(core_clk), .srst(srst), .bus(bus), .array_rdata(~bus.addr),
		.array_fail(array_fail), .array_wr(array_wr), .array_re(), .array_addr(),
		.array_wdata(), .erase_go(erase_go), .erase_mask(erase_mask),
		.protect_mask(protect_mask), .seq_state(seq_state));
	flash_command_sequencer #(.PROG_CYCLES(8), .ERASE_CYCLES(ERASE_N)) i_flash_command_sequencer_b (
		.core_clk(core_clk), .srst(srst), .bus(bus_b), .array_rdata(32'h0),
		.array_fail(fail_b), .array_wr(), .array_re(), .array_addr(), .array_wdata(),
		.erase_go(), .erase_mask(), .protect_mask(), .seq_state(state_b));
	flash_cpu_master i_flash_cpu_master (
		.core_clk(core_clk), .srst(srst), .bus(bus), .op_start(op_start), .op_kind(op_kind),
		.op_addr(op_addr), .op_code(op_code), .abort(abort), .word_data({24'h0, wcnt}),
		.word_take(word_take), .rd_start(rd_start), .rd_addr(rd_addr), .rd_data(rd_data),
		.rd_done(rd_done), .rd_fail(rd_fail), .op_busy(op_busy), .op_done(op_done));
	flash_seq_asserts #(.ERASE_CYCLES(ERASE_N)) i_flash_seq_asserts (
		.core_clk(core_clk), .srst(srst), .wr_valid(bus.wr_valid), .wr_word(bus.wr_word),
		.addr(bus.addr), .wdata(bus.wdata), .rd_valid(bus.rd_valid), .rd_ack(bus.rd_ack),
		.rd_ok(bus.rd_ok), .rdata(bus.rdata), .ready_busy_flag(bus.ready_busy_flag));
	// Counts page words, array writes, erase launches and host bus writes.
	always @(posedge core_clk) begin
		if (word_take === 1'b1) wcnt <= wcnt + 8'h01;
		if (array_wr === 1'b1) n_wr <= n_wr + 1;
		if (erase_go === 1'b1) n_erase <= n_erase + 1;
		if (bus.wr_valid === 1'b1) n_bus <= n_bus + 1;
		if (bus.wr_valid === 1'b1 && bus.wr_word !== 1'b1) n_half <= n_half + 1;
	end

	// ==========================================================
	// Tasks
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic ready();
		for (int n = 0; n < 400 && bus.ready_busy_flag !== 1'b1; n++) tick(1);
		if (bus.ready_busy_flag !== 1'b1) fails++;
	endtask
	// Starts one host operation and waits until its last write has gone out.
	task automatic op(op_kind_t k, logic [31:0] a, logic [3:0] c);
		int n;
		op_kind = k;
		op_addr = a;
		op_code = c;
		op_start = 1'b1;
		tick(1);
		op_start = 1'b0;
		for (n = 0; n < 300 && op_done !== 1'b1; n++) tick(1);
		if (n == 300) fails++;
		// The last word is still on the bus; let the sequencer take it.
		tick(1);
	endtask
	task automatic rd(logic [31:0] a, logic ok, logic [31:0] d);
		rd_addr = a;
		rd_start = 1'b1;
		tick(1);
		rd_start = 1'b0;
		for (int n = 0; n < 10 && rd_done !== 1'b1; n++) tick(1);
		if (rd_done !== 1'b1) fails++;
		chk("rd_fail", {31'h0, !ok}, {31'h0, rd_fail});
		chk("rd_data", d, rd_data);
	endtask
	// One write on the lone bus; released lines show the inverse afterwards.
	task automatic bw(logic [15:0] a, logic [31:0] d, logic w = 1'b1);
		bus_b.addr = {16'h0, a};
		bus_b.wdata = d;
		bus_b.wr_word = w;
		bus_b.wr_valid = 1'b1;
		tick(1);
		bus_b.wr_valid = 1'b0;
		bus_b.addr = ~{16'h0, a};
		bus_b.wdata = ~d;
		tick(1);
	endtask
	task automatic ul();
		bw(UNLOCK_ADDR1, UNLOCK_DATA1);
		bw(UNLOCK_ADDR2, UNLOCK_DATA2);
	endtask
	task automatic erase_b(logic [31:0] last);
		ul();
		bw(UNLOCK_ADDR1, CMD_ERASE);
		ul();
		bw(UNLOCK_ADDR1, last);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ==========================================================
	// Tests
	initial begin
		bus_b.wr_valid = 1'b0;
		bus_b.wr_word = 1'b1;
		bus_b.addr = 32'h0;
		bus_b.wdata = 32'h0;
		bus_b.rd_valid = 1'b0;
		tick(3);
		srst = 1'b0;
		tick(1);
		chk("protect_mask", 32'h0, protect_mask);
		rd(32'h0000_0100, 1'b1, ~32'h0000_0100);
		op(OP_ID, 32'h0, 4'h0);
		rd(32'h0000_0040, 1'b1, ID_CODE);
		rd(32'h0000_0044, 1'b1, ID_CODE);
		op(OP_READ_RESET, 32'h0, 4'h0);
		rd(32'h0000_0040, 1'b1, ~32'h0000_0040);
		op(OP_ID, 32'h0, 4'h0);
		op(OP_READ_CMD, 32'h0000_0800, 4'h0);
		rd(32'h0000_0048, 1'b1, ~32'h0000_0048);
		$display("test read modes finished");
		e0 = n_bus;
		op(OP_CHIP, 32'h0, 4'h0);
		rd(32'h0000_0080, 1'b0, 32'h0);
		ready();
		chk("erase count", 32'h1, n_erase);
		chk("erase_mask", 32'hF, erase_mask);
		chk("bus writes", 32'h7, n_bus - e0);
		chk("seq_state", S_READ, seq_state);
		op(OP_PROTECT, 32'h0, 4'h2);
		chk("protect_mask", 32'h2, protect_mask);
		op(OP_BLOCK, 32'h0002_0000, 4'h0);
		op(OP_PAGE, 32'h0002_0000, 4'h0);
		ready();
		chk("erase count", 32'h1, n_erase);
		chk("array writes", 32'h0, n_wr);
		op(OP_PAGE, 32'h0000_0200, 4'h0);
		ready();
		chk("array writes", 32'h80, n_wr);
		chk("flag", 32'h1, bus.ready_busy_flag);
		chk("op_busy", 32'h0, op_busy);
		abort = 1'b1;
		op(OP_PAGE, 32'h0000_0400, 4'h0);
		abort = 1'b0;
		ready();
		chk("array writes", 32'h80, n_wr);
		array_fail = 1'b1;
		op(OP_BLOCK, 32'h0004_0000, 4'h0);
		tick(3);
		chk("seq_state", S_FAIL, seq_state);
		chk("flag", 32'h0, bus.ready_busy_flag);
		chk("erase_mask", 32'h4, erase_mask);
		array_fail = 1'b0;
		srst = 1'b1;
		tick(1);
		srst = 1'b0;
		tick(1);
		chk("seq_state", S_READ, seq_state);
		chk("protect_mask", 32'h0, protect_mask);
		chk("half writes", 32'h0, n_half);
		$display("test host operations finished");
		ul();
		bw(UNLOCK_ADDR2, 32'h77);
		chk("state_b", S_READ, state_b);
		bw(UNLOCK_ADDR1, UNLOCK_DATA1);
		bw(UNLOCK_ADDR2, UNLOCK_DATA2, 1'b0);
		chk("state_b", S_READ, state_b);
		ul();
		bw(UNLOCK_ADDR1, CMD_ERASE);
		chk("state_b", S_CMD, state_b);
		bw(16'h0200, CMD_RESET);
		chk("state_b", S_READ, state_b);
		ul();
		bw(UNLOCK_ADDR1, CMD_ID);
		chk("state_b", S_ID, state_b);
		erase_b(CMD_CHIP);
		chk("state_b", S_ID, state_b);
		bw(16'h1234, CMD_RESET);
		chk("state_b", S_READ, state_b);
		erase_b(CMD_CHIP);
		chk("state_b", S_AUTO, state_b);
		bw(16'h0010, CMD_RESET);
		chk("state_b", S_AUTO, state_b);
		fail_b = 1'b1;
		tick(1);
		chk("state_b", S_FAIL, state_b);
		fail_b = 1'b0;
		bw(16'h0010, CMD_RESET);
		chk("state_b", S_READ, state_b);
		$display("test lone sequencer finished");
		test_done();
	end
	// Cuts a hang short well beyond the few hundred cycles the tests need.
	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		test_done();
	end
endmodule // tb_top
